// ---- spmc_defines.vh ----
// Constants for the steering program mode control block
`ifndef SPMC_DEFINES_VH
`define SPMC_DEFINES_VH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define SPMC_PROG_W        4
`define SPMC_ADC_W         10
`define SPMC_SPEED_W       10
`define SPMC_POS_W         10
`define SPMC_PWM_W         8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SPMC_PROG_RST      4'h0
`define SPMC_SPEED_THR_RST 10'h032

// ----------------------------------------------------------------
// Timing (clock 10 MHz)
// ----------------------------------------------------------------
`define SPMC_CLK_HZ        10000000
`define SPMC_APPLY_MS      50
`define SPMC_APPLY_CYC     ((`SPMC_CLK_HZ / 1000) * `SPMC_APPLY_MS)
`define SPMC_TICK_CYC      16'h2710
`define SPMC_NEUTRAL_TOL   10'h010

// ----------------------------------------------------------------
// Indicator encoding
// ----------------------------------------------------------------
`define SPMC_LED_OFF       2'h0
`define SPMC_LED_GREEN     2'h1
`define SPMC_LED_YELLOW    2'h2
`define SPMC_LED_RED       2'h3

`endif

// ---- spmc_spool_loop.v ----
// Spool position loop: error from set-point and feedback drives PWM
`timescale 1ns/1ps
`include "spmc_defines.vh"

module spmc_spool_loop (
    input  wire                      clk_sys,     // System clock
    input  wire                      rst,         // Synchronous reset, active high
    input  wire                      enable,      // Position control enabled
    input  wire                      tick,        // Regular control tick
    input  wire [`SPMC_POS_W-1:0]    setPoint,    // Spool set-point
    input  wire [`SPMC_POS_W-1:0]    feedback,    // Spool position sensor value
    output reg                       pwmExtend_r, // Solenoid drive, extend side
    output reg                       pwmRetract_r // Solenoid drive, retract side
);

// ----------------------------------------------------------------
// Duty update and PWM carrier
// ----------------------------------------------------------------
reg [`SPMC_PWM_W-1:0] duty_r;   // Current duty magnitude
reg                   dir_r;    // 1 = extend
reg [`SPMC_PWM_W-1:0] carrier_r; // Free running carrier

wire [`SPMC_POS_W:0] diff = {1'b0, setPoint} - {1'b0, feedback};
wire                 neg  = diff[`SPMC_POS_W];
wire [`SPMC_POS_W-1:0] mag = neg ? (~diff[`SPMC_POS_W-1:0] + 10'h001)
                                 : diff[`SPMC_POS_W-1:0];

// Duty taken only on the control tick, so the loop runs at a fixed rate
always @(posedge clk_sys) begin
    if (rst || !enable) begin
        duty_r <= 8'h00;
        dir_r  <= 1'b0;
    end else if (tick) begin
        // Saturate: large errors run at full drive   [R07]
        duty_r <= (mag[`SPMC_POS_W-1:8] != 2'h0) ? 8'hff : mag[7:0];
        dir_r  <= ~neg;
    end
end

// Carrier and comparator produce the solenoid PWM   [R08]
always @(posedge clk_sys) begin
    if (rst) begin
        carrier_r    <= 8'h00;
        pwmExtend_r  <= 1'b0;
        pwmRetract_r <= 1'b0;
    end else begin
        carrier_r    <= carrier_r + 8'h01;
        pwmExtend_r  <= enable && dir_r && (carrier_r < duty_r);
        pwmRetract_r <= enable && !dir_r && (carrier_r < duty_r);
    end
end

endmodule

// ---- spmc_program_control.v ----
// Steering program mode control: program change, health indicator, valve drive
`timescale 1ns/1ps
`include "spmc_defines.vh"
// Function
// R01 - Apply program only if all conditions hold
// R02 - Controller sends program select command
// R03 - Accepted command executes and is acknowledged
// R04 - Status report always carries active program
// R05 - Convert two 0-5 V inputs to 10 bits
// R06 - Run control and checks at fixed intervals
// R07 - Solenoid drive from set-point/feedback difference
// R08 - Spool positioned by PWM solenoid drive
// R09 - Exactly one of four health states shown
// R10 - Green only while controlling the spool
// R11 - Yellow for power save, idle, or fault
// R12 - Bus diagnostics stay alive in yellow
// R13 - Critical fault: red, valves and diagnostics off
// R14 - Error buffer readable while yellow
// R15 - Accepted change applied within 50 ms
// R16 - Check speed, neutral spool, actuator limits
// R17 - Rejection keeps program, sends no acknowledge
// R18 - Red until power-up; no changes in yellow/red

module spmc_program_control (
    input  wire                      clk_sys,        // System clock, 10 MHz
    input  wire                      rst,            // Synchronous reset (power-up)
    input  wire                      progSelValid,   // Program select command pulse
    input  wire [`SPMC_PROG_W-1:0]   progSelId,      // Requested program
    input  wire [`SPMC_SPEED_W-1:0]  vehicleSpeed,   // Vehicle speed
    input  wire                      speedPresent,   // Speed signal present
    input  wire [`SPMC_SPEED_W-1:0]  speedThreshold, // Max speed for transition
    input  wire [`SPMC_POS_W-1:0]    actuatorPos,    // Steering actuator position
    input  wire [`SPMC_POS_W-1:0]    actLimitRight,  // Lower actuator limit
    input  wire [`SPMC_POS_W-1:0]    actLimitLeft,   // Upper actuator limit
    input  wire [`SPMC_POS_W-1:0]    spoolSetPoint,  // Spool set-point
    input  wire [`SPMC_ADC_W-1:0]    spoolNeutral,   // Neutral spool position
    input  wire                      adcDone,        // Converter result valid pulse
    input  wire                      adcChan,        // Channel of the result
    input  wire [`SPMC_ADC_W-1:0]    adcCode,        // 10-bit converter code
    input  wire [`SPMC_POS_W-1:0]    spoolSensor,    // Spool position sensor code
    input  wire                      powerSave,      // Power-saving request (pin)
    input  wire                      operateReq,     // First operation request (pin)
    input  wire                      majorFault,     // Major fault / bad reception (pin)
    input  wire                      criticalFault,  // Critical fault (pin)
    input  wire                      errBufRdReq,    // Error buffer read request
    output reg                       progSelAck_r,   // Program select acknowledge pulse
    output reg  [`SPMC_PROG_W-1:0]   activeProg_r,   // Active program for status report
    output reg                       statusStrobe_r, // Periodic status report pulse
    output reg                       diagEnable_r,   // Bus diagnostics enabled
    output reg                       errBufRdGrant_r,// Error buffer read granted
    output reg  [1:0]                ledState_r,     // Indicator colour
    output reg  [`SPMC_ADC_W-1:0]    analog0_r,      // Input 0 value
    output reg  [`SPMC_ADC_W-1:0]    analog1_r,      // Input 1 value
    output reg                       pwmExtend_r,    // Solenoid PWM, extend
    output reg                       pwmRetract_r    // Solenoid PWM, retract
);

// ----------------------------------------------------------------
// Pin synchronisers (three stages, change taken when 2 and 3 agree)
// ----------------------------------------------------------------
reg [2:0] psSync_r;   // Power save
reg [2:0] opSync_r;   // Operate request
reg [2:0] mfSync_r;   // Major fault
reg [2:0] cfSync_r;   // Critical fault
reg       psLvl_r;    // Filtered levels
reg       opLvl_r;
reg       mfLvl_r;
reg       cfLvl_r;

always @(posedge clk_sys) begin
    if (rst) begin
        psSync_r <= 3'h0;
        opSync_r <= 3'h0;
        mfSync_r <= 3'h0;
        cfSync_r <= 3'h0;
        psLvl_r  <= 1'b0;
        opLvl_r  <= 1'b0;
        mfLvl_r  <= 1'b0;
        cfLvl_r  <= 1'b0;
    end else begin
        psSync_r <= {psSync_r[1:0], powerSave};
        opSync_r <= {opSync_r[1:0], operateReq};
        mfSync_r <= {mfSync_r[1:0], majorFault};
        cfSync_r <= {cfSync_r[1:0], criticalFault};
        // Stage one is never looked at, only stages two and three
        if (psSync_r[1] == psSync_r[2]) psLvl_r <= psSync_r[2];
        if (opSync_r[1] == opSync_r[2]) opLvl_r <= opSync_r[2];
        if (mfSync_r[1] == mfSync_r[2]) mfLvl_r <= mfSync_r[2];
        if (cfSync_r[1] == cfSync_r[2]) cfLvl_r <= cfSync_r[2];
    end
end

// ----------------------------------------------------------------
// Fixed-interval control tick
// ----------------------------------------------------------------
reg [15:0] tickCnt_r; // Tick divider
reg        tick_r;    // One-cycle tick

// A free divider gives a strictly periodic schedule   [R06]
always @(posedge clk_sys) begin
    if (rst) begin
        tickCnt_r <= 16'h0000;
        tick_r    <= 1'b0;
    end else if (tickCnt_r == `SPMC_TICK_CYC - 16'h0001) begin
        tickCnt_r <= 16'h0000;
        tick_r    <= 1'b1;
    end else begin
        tickCnt_r <= tickCnt_r + 16'h0001;
        tick_r    <= 1'b0;
    end
end

// ----------------------------------------------------------------
// Health state machine (one-hot)
// ----------------------------------------------------------------
localparam [3:0] ST_OFF    = 4'h1; // Held in reset only
localparam [3:0] ST_YELLOW = 4'h2;
localparam [3:0] ST_GREEN  = 4'h4;
localparam [3:0] ST_RED    = 4'h8;

reg [3:0] health_r;   // Current health state
reg [3:0] health_nxt; // Next health state
reg       latchedMf_r; // Major fault seen; stays until power-up

always @* begin
    health_nxt = health_r;
    case (health_r)
        ST_OFF: begin
            health_nxt = ST_YELLOW;                 // Valves off until operated [R11]
        end
        ST_YELLOW: begin
            if (cfLvl_r)
                health_nxt = ST_RED;                // [R13]
            else if (opLvl_r && !psLvl_r && !latchedMf_r && !mfLvl_r)
                health_nxt = ST_GREEN;
        end
        ST_GREEN: begin
            if (cfLvl_r)
                health_nxt = ST_RED;                // [R13]
            else if (psLvl_r || mfLvl_r)
                health_nxt = ST_YELLOW;             // Power save or major fault [R11]
        end
        ST_RED: begin
            health_nxt = ST_RED;                    // Left only by reset [R18]
        end
        default: begin
            health_nxt = ST_RED;                    // Corrupt state treated as critical
        end
    endcase
end

always @(posedge clk_sys) begin
    if (rst) begin
        health_r    <= ST_OFF;
        latchedMf_r <= 1'b0;
    end else begin
        health_r <= health_nxt;
        if (mfLvl_r)
            latchedMf_r <= 1'b1;                    // Permanent disable [R11]
    end
end

wire inGreen  = (health_r == ST_GREEN);
wire inYellow = (health_r == ST_YELLOW);

// Indicator, diagnostics and error buffer gating
always @(posedge clk_sys) begin
    if (rst) begin
        ledState_r      <= `SPMC_LED_OFF;
        diagEnable_r    <= 1'b0;
        errBufRdGrant_r <= 1'b0;
    end else begin
        // One colour per state [R09]
        case (health_nxt)
            ST_GREEN:  ledState_r <= `SPMC_LED_GREEN;   // [R10]
            ST_YELLOW: ledState_r <= `SPMC_LED_YELLOW;  // [R11]
            ST_RED:    ledState_r <= `SPMC_LED_RED;     // [R13]
            default:   ledState_r <= `SPMC_LED_OFF;
        endcase
        diagEnable_r    <= (health_nxt != ST_RED) && (health_nxt != ST_OFF); // [R12] [R13]
        errBufRdGrant_r <= errBufRdReq && inYellow;                          // [R14]
    end
end

// ----------------------------------------------------------------
// Analogue capture
// ----------------------------------------------------------------
// Converter delivers 0..1023 for 0..5 V; the code is stored per channel
always @(posedge clk_sys) begin
    if (rst) begin
        analog0_r <= 10'h000;
        analog1_r <= 10'h000;
    end else if (adcDone) begin
        if (adcChan)
            analog1_r <= adcCode;                   // [R05]
        else
            analog0_r <= adcCode;                   // [R05]
    end
end

// ----------------------------------------------------------------
// Program transition
// ----------------------------------------------------------------
function [`SPMC_POS_W-1:0] absDiff;
    input [`SPMC_POS_W-1:0] a;
    input [`SPMC_POS_W-1:0] b;
    begin
        absDiff = (a > b) ? (a - b) : (b - a);
    end
endfunction

// Speed check is waived when no speed signal is present
wire speedOk   = !speedPresent || (vehicleSpeed <= speedThreshold);
wire neutralOk = absDiff(spoolSensor, spoolNeutral) <= `SPMC_NEUTRAL_TOL;
wire posOk     = (actuatorPos >= actLimitRight) && (actuatorPos <= actLimitLeft);
wire stateOk   = speedOk && neutralOk && posOk;       // [R16]

// Decision is made in the cycle after the command, far inside 50 ms;
// a request that fails the check is dropped at once; nothing is held pending
always @(posedge clk_sys) begin
    if (rst) begin
        activeProg_r <= `SPMC_PROG_RST;
        progSelAck_r <= 1'b0;
    end else begin
        progSelAck_r <= 1'b0;
        // Command arrives from the controller [R02]
        if (progSelValid && inGreen && stateOk) begin
            activeProg_r <= progSelId;              // [R01] [R15]
            progSelAck_r <= 1'b1;                   // [R03]
        end
        // Otherwise program and acknowledge untouched [R17] [R18]
    end
end

// Status report pulse on every tick while diagnostics are alive
always @(posedge clk_sys) begin
    if (rst)
        statusStrobe_r <= 1'b0;
    else
        statusStrobe_r <= tick_r && diagEnable_r;   // Carries activeProg_r [R04]
end

// ----------------------------------------------------------------
// Spool position loop
// ----------------------------------------------------------------
wire pwmExt; // Loop outputs
wire pwmRet;

spmc_spool_loop uLoop (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .enable       (inGreen),
    .tick         (tick_r),
    .setPoint     (spoolSetPoint),
    .feedback     (spoolSensor),
    .pwmExtend_r  (pwmExt),
    .pwmRetract_r (pwmRet)
);

// Drive masked outside green so red or yellow silences the valves
always @(posedge clk_sys) begin
    if (rst) begin
        pwmExtend_r  <= 1'b0;
        pwmRetract_r <= 1'b0;
    end else begin
        pwmExtend_r  <= pwmExt && inGreen;          // [R10] [R13]
        pwmRetract_r <= pwmRet && inGreen;          // [R08]
    end
end

endmodule

// ---- spmc_ctrl_unit_model.sv ----
// Control unit model that issues program select commands to the block
`timescale 1ns/1ps
module spmc_ctrl_unit_model (
    input  wire       clk_sys,    // System clock
    input  wire       sendReq,    // Issue one command this cycle
    input  wire [3:0] sendId,     // Program to request
    output reg        cmdValid_r, // Command pulse
    output reg  [3:0] cmdId_r     // Requested program
);
    // ------------------------------------------------------------
    // Command launch
    // ------------------------------------------------------------
    initial begin
        cmdValid_r = 1'b0;
        cmdId_r = 4'h0;
    end
    // Id toggles while idle, so a stale id can never pass for a fresh one
    always @(posedge clk_sys) begin
        cmdValid_r <= sendReq;
        cmdId_r <= sendReq ? sendId : ~cmdId_r;
    end
endmodule

// ---- spmc_checker_properties.sv ----
// Assertion checker for the program mode control block
`timescale 1ns/1ps
`include "spmc_defines.vh"
module spmc_checker (
    input wire       clk_sys,         // Clock
    input wire       rst,             // Reset
    input wire       progSelValid,    // Command pulse
    input wire [3:0] progSelId,       // Requested program
    input wire [9:0] vehicleSpeed,    // Speed
    input wire       speedPresent,    // Speed present
    input wire [9:0] speedThreshold,  // Speed limit
    input wire [9:0] actuatorPos,     // Actuator position
    input wire [9:0] actLimitRight,   // Low limit
    input wire [9:0] actLimitLeft,    // High limit
    input wire [9:0] spoolNeutral,    // Neutral code
    input wire [9:0] spoolSensor,     // Spool feedback
    input wire       adcDone,         // Result pulse
    input wire       adcChan,         // Result channel
    input wire [9:0] adcCode,         // Result code
    input wire       errBufRdReq,     // Buffer read request
    input wire       progSelAck_r,    // Acknowledge
    input wire [3:0] activeProg_r,    // Active program
    input wire       diagEnable_r,    // Diagnostics on
    input wire       errBufRdGrant_r, // Buffer grant
    input wire [1:0] ledState_r,      // Indicator
    input wire [9:0] analog0_r,       // Input 0 value
    input wire [9:0] analog1_r,       // Input 1 value
    input wire       pwmExtend_r,     // Extend drive
    input wire       pwmRetract_r     // Retract drive
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Spool distance from neutral, either side, no wrap
    wire [9:0] offN = (spoolSensor > spoolNeutral) ? spoolSensor - spoolNeutral
                                                   : spoolNeutral - spoolSensor;
    wire       green = (ledState_r == `SPMC_LED_GREEN); // Spool control live
    // All transition conditions together
    wire       take = progSelValid && green && offN <= `SPMC_NEUTRAL_TOL
        && (!speedPresent || vehicleSpeed <= speedThreshold)
        && actuatorPos >= actLimitRight && actuatorPos <= actLimitLeft;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    accept_ack_a:
        assert property (take |=> progSelAck_r && activeProg_r == $past(progSelId))
        else $error("accepted command not applied");
    reject_quiet_a:
        assert property (progSelValid && !take |=> !progSelAck_r)
        else $error("refused command acknowledged");
    prog_hold_a:
        assert property (!progSelAck_r && !$past(rst) |-> $stable(activeProg_r))
        else $error("program changed without acknowledge");
    locked_out_a:
        assert property (!green |=> !progSelAck_r)
        else $error("acknowledge outside green");
    red_sticky_a:
        assert property (ledState_r == `SPMC_LED_RED |=> ledState_r == `SPMC_LED_RED)
        else $error("left red without reset");
    red_silent_a:
        assert property (ledState_r == `SPMC_LED_RED && $past(ledState_r, 2) == `SPMC_LED_RED
            |-> !diagEnable_r && !pwmExtend_r && !pwmRetract_r)
        else $error("red state not silent");
    yellow_idle_a:
        assert property (ledState_r == `SPMC_LED_YELLOW
            && $past(ledState_r, 2) == `SPMC_LED_YELLOW
            |-> diagEnable_r && !pwmExtend_r && !pwmRetract_r)
        else $error("yellow state drive or diagnostics wrong");
    grant_yellow_a:
        assert property (!$past(rst) |->
            errBufRdGrant_r == $past(errBufRdReq && ledState_r == `SPMC_LED_YELLOW))
        else $error("error buffer grant wrong");
    adc_capture_a:
        assert property (adcDone |=> ($past(adcChan) ? analog1_r : analog0_r) == $past(adcCode))
        else $error("converter result not captured");
endmodule
bind spmc_program_control spmc_checker u_chk (.*);

// ---- spmc_program_control_tb_top.sv ----
// Self-checking bench for the program mode control block
`timescale 1ns/1ps
`include "spmc_defines.vh"
module spmc_program_control_tb_top;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    reg clk_sys = 1'b0, rst = 1'b1, sendReq = 1'b0;               // Clock, reset, launch
    reg [9:0] vehicleSpeed = 10'h000, speedThreshold = 10'h032;  // Speed check
    reg [9:0] actuatorPos = 10'h100, actLimitRight = 10'h080, actLimitLeft = 10'h300;
    reg [9:0] spoolSetPoint = 10'h200, spoolNeutral = 10'h200, spoolSensor = 10'h200;
    reg [9:0] adcCode = 10'h000;                                  // Converter code
    reg speedPresent = 1'b1, adcDone = 1'b0, adcChan = 1'b0, powerSave = 1'b0;
    reg operateReq = 1'b0, majorFault = 1'b0, criticalFault = 1'b0, errBufRdReq = 1'b0;
    reg [3:0] sendId = 4'h0, expProg = 4'h0;                      // Launch id, model
    wire progSelValid, progSelAck_r, statusStrobe_r, diagEnable_r, errBufRdGrant_r;
    wire pwmExtend_r, pwmRetract_r;                               // Valve drive
    wire [3:0] progSelId, activeProg_r;                           // Programs
    wire [1:0] ledState_r;                                        // Indicator
    wire [9:0] analog0_r, analog1_r;                              // Inputs
    int fails = 0, testsRun = 0, i;                               // Counters
    logic ext, ret, stb;                                          // Seen flags
    typedef struct { logic [3:0] id; logic [9:0] spd; logic pr; logic [9:0] ps;
                     logic [9:0] sn; logic ak; } spmc_row_t;
    spmc_row_t rows [0:8];                                        // Request cases

    always #50 clk_sys = ~clk_sys; // 10 MHz
    spmc_ctrl_unit_model u_cu (.clk_sys(clk_sys), .sendReq(sendReq), .sendId(sendId),
                               .cmdValid_r(progSelValid), .cmdId_r(progSelId));
    spmc_program_control u_dut (.*);

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        testsRun++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One command through the model; returns just after the answer edge
    task send(input logic [3:0] id);
        @(posedge clk_sys);
        sendReq <= 1'b1;
        sendId <= id;
        @(posedge clk_sys);
        sendReq <= 1'b0;
        @(posedge clk_sys);
        #1;
    endtask
    // Bounded wait for an indicator colour; sync stages take a few edges
    task waitLed(input logic [1:0] v);
        for (int k = 0; k < 20 && ledState_r !== v; k++) @(posedge clk_sys);
        #1;
        check("led", {14'h0, v}, {14'h0, ledState_r});
    endtask
    task end_of_test;
        $display("comparisons %0d mismatches %0d", testsRun, fails);
        if (fails == 0 && testsRun > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Watchdog well past the pwm window
    initial begin
        #(40000 * 100);
        fails++;
        end_of_test;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rows = '{'{4'h5, 10'h032, 1, 10'h100, 10'h200, 1}, '{4'h6, 10'h033, 1, 10'h100, 10'h200, 0},
                 '{4'h7, 10'h3e8, 0, 10'h100, 10'h200, 1}, '{4'h8, 10'h000, 1, 10'h100, 10'h210, 1},
                 '{4'h9, 10'h000, 1, 10'h100, 10'h211, 0}, '{4'ha, 10'h000, 1, 10'h100, 10'h1ef, 0},
                 '{4'hb, 10'h000, 1, 10'h080, 10'h200, 1}, '{4'hc, 10'h000, 1, 10'h301, 10'h200, 0},
                 '{4'hd, 10'h000, 1, 10'h07f, 10'h200, 0}};
        repeat (7) @(posedge clk_sys);
        #1;
        check("led in reset", 16'h0, {14'h0, ledState_r});
        @(posedge clk_sys);
        rst <= 1'b0;
        waitLed(`SPMC_LED_YELLOW);
        check("diag", 16'h1, {15'h0, diagEnable_r});
        send(4'h3);
        check("ack yellow", 16'h0, {15'h0, progSelAck_r});
        operateReq <= 1'b1;
        waitLed(`SPMC_LED_GREEN);
        $display("test start done");
        for (i = 0; i < 9; i++) begin
            @(posedge clk_sys);
            vehicleSpeed <= rows[i].spd;
            speedPresent <= rows[i].pr;
            actuatorPos <= rows[i].ps;
            spoolSensor <= rows[i].sn;
            send(rows[i].id);
            if (rows[i].ak) expProg = rows[i].id;
            check("ack", {15'h0, rows[i].ak}, {15'h0, progSelAck_r});
            check("program", {12'h0, expProg}, {12'h0, activeProg_r});
        end
        spoolSensor <= 10'h200;
        actuatorPos <= 10'h100; // Last row left the actuator outside its limits
        $display("test rows done");
        @(posedge clk_sys);
        sendReq <= 1'b1;
        sendId <= 4'h1;
        @(posedge clk_sys);
        sendId <= 4'h2;
        @(posedge clk_sys);
        sendReq <= 1'b0;
        adcDone <= 1'b1;
        adcCode <= 10'h3ff;
        #1;
        check("first of pair", 16'h1, {12'h0, activeProg_r});
        @(posedge clk_sys);
        adcChan <= 1'b1;
        adcCode <= 10'h155;
        #1;
        check("second of pair", 16'h2, {12'h0, activeProg_r});
        @(posedge clk_sys);
        adcDone <= 1'b0;
        spoolSetPoint <= 10'h3ff;
        #1;
        check("input 0", 16'h03ff, {6'h0, analog0_r});
        check("input 1", 16'h0155, {6'h0, analog1_r});
        expProg = 4'h2;
        $display("test pair and inputs done");
        {ext, ret, stb} = 3'b000;
        repeat (10100) begin
            @(posedge clk_sys);
            #1;
            {ext, ret, stb} = {ext | pwmExtend_r, ret | pwmRetract_r, stb | statusStrobe_r};
        end
        check("extend seen", 16'h1, {15'h0, ext});
        check("retract seen", 16'h0, {15'h0, ret});
        check("status seen", 16'h1, {15'h0, stb});
        $display("test drive done");
        errBufRdReq <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        check("grant green", 16'h0, {15'h0, errBufRdGrant_r});
        powerSave <= 1'b1;
        waitLed(`SPMC_LED_YELLOW);
        @(posedge clk_sys);
        #1;
        check("grant yellow", 16'h1, {15'h0, errBufRdGrant_r});
        powerSave <= 1'b0;
        waitLed(`SPMC_LED_GREEN);
        majorFault <= 1'b1;
        waitLed(`SPMC_LED_YELLOW);
        majorFault <= 1'b0;
        repeat (10) @(posedge clk_sys);
        waitLed(`SPMC_LED_YELLOW);
        send(4'h9);
        check("program yellow", {12'h0, expProg}, {12'h0, activeProg_r});
        criticalFault <= 1'b1;
        waitLed(`SPMC_LED_RED);
        check("diag red", 16'h0, {15'h0, diagEnable_r});
        criticalFault <= 1'b0;
        repeat (10) @(posedge clk_sys);
        waitLed(`SPMC_LED_RED);
        $display("test faults done");
        rst <= 1'b1;
        repeat (8) @(posedge clk_sys);
        #1;
        check("program reset", 16'h0, {12'h0, activeProg_r});
        rst <= 1'b0;
        @(posedge clk_sys);
        waitLed(`SPMC_LED_YELLOW);
        waitLed(`SPMC_LED_GREEN);
        $display("test reset done");
        end_of_test;
    end
endmodule
